/* sto_pkg.sv */
// Purpose: constants and types for the safe thrust cutoff monitor
// Assumes: 125 MHz clock, byte register offsets on a 32-bit plain port
// Notes:   channel inputs are high while a channel is on
// Function
// - either channel off enters cutoff, thrust removed
// - upper channel off kills upper arm drive
// - lower channel off kills lower arm drive
// - off pulses below 1 ms are ignored
// - monitor active only when both channels off
// - monitor follows channels within 6 ms
// - cutoff drops servo ready, alarms, shows code
// - alarm clear only after both channels on
// - alarm dynamic brake follows alarm sequence
// - after clear, servo-off dynamic brake sequence
// - brake engages at hold time or low speed
// - over-speed raises error 26.0
// - deviation over limit raises error 24.0
// - source select picks command or feedback deviation
// - position beyond working range raises error 34.0
// - select 0 or 1 clamps to first limit
// - limit-active output while thrust is clamped
package sto_pkg;
    localparam int CLK_MHZ       = 125;
    localparam int FILTER_US     = 1000;
    localparam int FILTER_CYC    = FILTER_US * CLK_MHZ;
    localparam int MS_US         = 1000;
    localparam int MS_CYC        = MS_US * CLK_MHZ;
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_OVSPD  = 8'h08;
    localparam logic [7:0] A_DEVLIM = 8'h0c;
    localparam logic [7:0] A_DEVSRC = 8'h10;
    localparam logic [7:0] A_RANGE  = 8'h14;
    localparam logic [7:0] A_TLSEL  = 8'h18;
    localparam logic [7:0] A_TLIM1  = 8'h1c;
    localparam logic [7:0] A_BHOLD  = 8'h20;
    localparam logic [7:0] A_BRSPD  = 8'h24;
    localparam logic [7:0] A_ALSEQ  = 8'h28;
    localparam logic [7:0] A_OFFSEQ = 8'h2c;
    localparam int CTRL_CLR_BIT  = 0;
    localparam int ST_CODE_LSB   = 8;
    localparam logic [7:0] ERR_OVERSPEED = 8'h1a;
    localparam logic [7:0] ERR_DEVIATION = 8'h18;
    localparam logic [7:0] ERR_SOFTLIMIT = 8'h22;
    localparam logic [7:0] ERR_SAFETY    = 8'h1f;
    localparam logic [7:0] ERR_NONE      = 8'h00;
    typedef struct packed {
        logic [15:0] overspeed_level;
        logic [31:0] deviation_limit;
        logic        deviation_source_select;
        logic [31:0] working_range;
        logic [1:0]  thrust_limit_select;
        logic [15:0] first_thrust_limit;
        logic [15:0] brake_hold_time;
        logic [15:0] brake_release_speed;
        logic        alarm_stop_sequence;
        logic        servo_off_sequence;
    } cfg_t;
    localparam cfg_t CFG_RESET = '{
        overspeed_level:         16'hffff,
        deviation_limit:         32'hffffffff,
        deviation_source_select: 1'h0,
        working_range:           32'h7fffffff,
        thrust_limit_select:     2'h0,
        first_thrust_limit:      16'h7fff,
        brake_hold_time:         16'h0064,
        brake_release_speed:     16'h0000,
        alarm_stop_sequence:     1'h1,
        servo_off_sequence:      1'h1
    };
    typedef struct packed {
        logic        gate_upper;
        logic        gate_lower;
        logic        dyn_brake;
        logic        brake_release;
    } drive_t;
endpackage

/* safe_thrust_off_monitor.sv */
// Purpose: safety cutoff, alarm sequencing and protection checks
// Assumes: all inputs synchronous to ref_clk_in except the safety channels and rst_n_in
// Notes:   brake hold time counts in 1 ms steps from a divider
`timescale 1ns/1ns
module safe_thrust_off_monitor
    import sto_pkg::*;
#(
    parameter int FILTER_CYCLES = FILTER_CYC,
    parameter int MS_CYCLES     = MS_CYC
)(
    input  wire logic               ref_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               safety_in_upper_in,
    input  wire logic               safety_in_lower_in,
    input  wire logic               servo_on_in,
    input  wire logic               position_mode_in,
    input  wire logic [15:0]        motor_speed_in,
    input  wire logic signed [31:0] dev_cmd_in,
    input  wire logic signed [31:0] dev_fb_in,
    input  wire logic signed [31:0] motor_pos_in,
    input  wire logic signed [15:0] thrust_cmd_in,
    input  wire logic [7:0]         addr_in,
    input  wire logic [31:0]        wdata_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    output logic [31:0]             rdata_out,
    output logic                    gate_upper_out,
    output logic                    gate_lower_out,
    output logic                    safety_monitor_out,
    output logic                    servo_ready_out,
    output logic                    alarm_out,
    output logic [7:0]              err_code_out,
    output logic                    dyn_brake_out,
    output logic                    brake_release_out,
    output logic signed [15:0]      thrust_out,
    output logic                    thrust_limit_active_out
);
    typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_STOP} brk_st_t;

    // reset release through two flops
    logic rst_s1_r, rst_n;
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // per channel: synchroniser and off-pulse filter
    logic [1:0]  raw;
    logic [1:0]  sync1_r;
    logic [1:0]  sync2_r;
    logic [1:0]  ch_on_r;
    logic [31:0] cnt_r [2];
    assign raw = {safety_in_lower_in, safety_in_upper_in};
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_ch
            logic        differs;
            logic [31:0] cnt_nxt;
            assign differs = (sync2_r[i] != ch_on_r[i]);
            assign cnt_nxt = differs ? cnt_r[i] + 32'h1 : 32'h0;
            always_ff @(posedge ref_clk_in or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    sync1_r[i] <= 1'b0;
                    sync2_r[i] <= 1'b0;
                    ch_on_r[i] <= 1'b0;
                    cnt_r[i]   <= 32'h0;
                end
                else
                begin
                    sync1_r[i] <= raw[i];
                    sync2_r[i] <= sync1_r[i];
                    // accept a change only after it stood a full filter time
                    if (differs && cnt_r[i] >= 32'(FILTER_CYCLES - 1))
                    begin
                        ch_on_r[i] <= sync2_r[i];
                        cnt_r[i]   <= 32'h0;
                    end
                    else
                    begin
                        cnt_r[i] <= cnt_nxt;
                    end
                end
            end
        end
    endgenerate

    // configuration registers and bus decode
    cfg_t        cfg_r;
    logic        clr_req;
    logic [31:0] rd_mux;
    logic        cutoff;
    logic        alarm_r;
    logic [7:0]  code_r;
    logic        mon_r;
    brk_st_t     st_r;
    logic        tla_r;
    logic [31:0] status_w;
    assign clr_req = wr_in && addr_in == A_CTRL && wdata_in[CTRL_CLR_BIT];
    assign status_w = {16'h0, code_r, 2'h0, tla_r, st_r != ST_STOP,
                       servo_ready_out, mon_r, alarm_r, cutoff};
    always_comb
    begin
        case (addr_in)
            A_STATUS: rd_mux = status_w;
            A_OVSPD:  rd_mux = {16'h0, cfg_r.overspeed_level};
            A_DEVLIM: rd_mux = cfg_r.deviation_limit;
            A_DEVSRC: rd_mux = {31'h0, cfg_r.deviation_source_select};
            A_RANGE:  rd_mux = cfg_r.working_range;
            A_TLSEL:  rd_mux = {30'h0, cfg_r.thrust_limit_select};
            A_TLIM1:  rd_mux = {16'h0, cfg_r.first_thrust_limit};
            A_BHOLD:  rd_mux = {16'h0, cfg_r.brake_hold_time};
            A_BRSPD:  rd_mux = {16'h0, cfg_r.brake_release_speed};
            A_ALSEQ:  rd_mux = {31'h0, cfg_r.alarm_stop_sequence};
            A_OFFSEQ: rd_mux = {31'h0, cfg_r.servo_off_sequence};
            default:  rd_mux = 32'h0;
        endcase
    end

    // register writes and read data one cycle later
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_r     <= CFG_RESET;
            rdata_out <= 32'h0;
        end
        else
        begin
            rdata_out <= rd_in ? rd_mux : 32'h0;
            if (wr_in)
            begin
                case (addr_in)
                    A_OVSPD:  cfg_r.overspeed_level <= wdata_in[15:0];
                    A_DEVLIM: cfg_r.deviation_limit <= wdata_in;
                    A_DEVSRC: cfg_r.deviation_source_select <= wdata_in[0];
                    A_RANGE:  cfg_r.working_range <= wdata_in;
                    A_TLSEL:  cfg_r.thrust_limit_select <= wdata_in[1:0];
                    A_TLIM1:  cfg_r.first_thrust_limit <= wdata_in[15:0];
                    A_BHOLD:  cfg_r.brake_hold_time <= wdata_in[15:0];
                    A_BRSPD:  cfg_r.brake_release_speed <= wdata_in[15:0];
                    A_ALSEQ:  cfg_r.alarm_stop_sequence <= wdata_in[0];
                    A_OFFSEQ: cfg_r.servo_off_sequence <= wdata_in[0];
                    default:  cfg_r <= cfg_r;
                endcase
            end
        end
    end

    // protection checks
    logic        run;
    logic [31:0] dev_sel;
    logic [31:0] dev_abs;
    logic [31:0] pos_abs;
    logic        err_speed, err_dev, err_range;
    logic        both_on_r, restore_err;
    logic        set_any;
    logic [7:0]  code_sel;
    assign cutoff    = !ch_on_r[0] || !ch_on_r[1];
    assign run       = servo_on_in && !alarm_r;
    assign dev_sel   = cfg_r.deviation_source_select ? dev_fb_in : dev_cmd_in;
    assign dev_abs   = dev_sel[31] ? 32'(-dev_sel) : dev_sel;
    assign pos_abs   = motor_pos_in[31] ? 32'(-motor_pos_in) : motor_pos_in;
    assign err_speed = motor_speed_in > cfg_r.overspeed_level;
    assign err_dev   = position_mode_in && dev_abs > cfg_r.deviation_limit;
    assign err_range = position_mode_in && pos_abs > cfg_r.working_range;
    // channels restored while servo-on is still asserted
    assign restore_err = !cutoff && !both_on_r && servo_on_in;
    assign set_any   = cutoff || restore_err || err_speed || err_dev || err_range;
    assign code_sel  = (cutoff || restore_err) ? ERR_SAFETY :
                       err_speed ? ERR_OVERSPEED :
                       err_dev   ? ERR_DEVIATION : ERR_SOFTLIMIT;

    // alarm latch; a cause present at clear time keeps the alarm
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_r   <= 1'b0;
            code_r    <= ERR_NONE;
            both_on_r <= 1'b0;
            mon_r     <= 1'b0;
        end
        else
        begin
            both_on_r <= !cutoff;
            mon_r     <= !ch_on_r[0] && !ch_on_r[1];
            if (set_any)
            begin
                alarm_r <= 1'b1;
                if (!alarm_r || clr_req)
                    code_r <= code_sel;
            end
            else if (clr_req)
            begin
                alarm_r <= 1'b0;
                code_r  <= ERR_NONE;
            end
        end
    end

    // 1 ms tick for the brake hold timer
    logic [31:0] ms_cnt_r;
    logic        ms_tick;
    assign ms_tick = ms_cnt_r >= 32'(MS_CYCLES - 1);
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            ms_cnt_r <= 32'h0;
        else
            ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
    end

    // mechanical brake sequencing after leaving run
    logic [15:0] hold_r;
    logic        hold_done;
    logic        slow;
    brk_st_t     st_nxt;
    assign slow      = motor_speed_in < cfg_r.brake_release_speed;
    assign hold_done = hold_r >= cfg_r.brake_hold_time;
    always_comb
    begin
        case (st_r)
            ST_RUN:  st_nxt = run ? ST_RUN : ST_HOLD;
            ST_HOLD: st_nxt = (hold_done || slow) ? ST_STOP : ST_HOLD;
            ST_STOP: st_nxt = run ? ST_RUN : ST_STOP;
            default: st_nxt = ST_STOP;
        endcase
    end
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r   <= ST_STOP;
            hold_r <= 16'h0;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_r != ST_HOLD)
                hold_r <= 16'h0;
            else if (ms_tick && !hold_done)
                hold_r <= hold_r + 16'h1;
        end
    end

    // thrust limit clamp
    logic        clamp_en;
    logic [15:0] cmd_abs;
    logic        over;
    logic signed [15:0] lim_s;
    logic signed [15:0] thr_nxt;
    assign clamp_en = cfg_r.thrust_limit_select <= 2'h1;
    assign cmd_abs  = thrust_cmd_in[15] ? 16'(-thrust_cmd_in) : thrust_cmd_in;
    assign over     = clamp_en && cmd_abs > cfg_r.first_thrust_limit;
    assign lim_s    = $signed(cfg_r.first_thrust_limit);
    assign thr_nxt  = !over ? thrust_cmd_in :
                      thrust_cmd_in[15] ? 16'(-lim_s) : lim_s;

    // drive outputs from flops
    drive_t drv_r, drv_nxt;
    logic signed [15:0] thr_r;
    always_comb
    begin
        drv_nxt.gate_upper    = run && ch_on_r[0];
        drv_nxt.gate_lower    = run && ch_on_r[1];
        drv_nxt.dyn_brake     = alarm_r ? cfg_r.alarm_stop_sequence :
                                !run ? cfg_r.servo_off_sequence : 1'b0;
        drv_nxt.brake_release = st_nxt != ST_STOP;
    end
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drv_r <= '0;
            thr_r <= 16'sh0;
            tla_r <= 1'b0;
        end
        else
        begin
            drv_r <= drv_nxt;
            thr_r <= (run && !cutoff) ? thr_nxt : 16'sh0;
            tla_r <= run && !cutoff && over;
        end
    end
    assign gate_upper_out          = drv_r.gate_upper;
    assign gate_lower_out          = drv_r.gate_lower;
    assign dyn_brake_out           = drv_r.dyn_brake;
    assign brake_release_out       = drv_r.brake_release;
    assign thrust_out              = thr_r;
    assign thrust_limit_active_out = tla_r;
    assign safety_monitor_out      = mon_r;
    assign servo_ready_out         = !alarm_r && !cutoff;
    assign alarm_out               = alarm_r;
    assign err_code_out            = code_r;

    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n);
    sequence s_cut_new;
        cutoff && !alarm_r;
    endsequence
    sequence s_alarm_shown;
        alarm_r && code_r == ERR_SAFETY && !servo_ready_out;
    endsequence
    a_upper_gate_off: assert property (!ch_on_r[0] |=> !gate_upper_out)
        else $error("upper gate on with channel off");
    a_lower_gate_off: assert property (!ch_on_r[1] |=> !gate_lower_out)
        else $error("lower gate on with channel off");
    a_cutoff_alarm_code: assert property (s_cut_new |=> s_alarm_shown)
        else $error("cutoff without safety alarm");
    a_cutoff_no_thrust: assert property (cutoff |=> thrust_out == 16'sh0)
        else $error("thrust with cutoff");
    a_monitor_both_off: assert property
        ((!ch_on_r[0] && !ch_on_r[1]) |=> safety_monitor_out)
        else $error("monitor not active with both off");
    a_monitor_one_on: assert property
        ((ch_on_r[0] || ch_on_r[1]) |=> !safety_monitor_out)
        else $error("monitor active with a channel on");
    a_filter_short_pulse: assert property
        ($changed(ch_on_r[0]) |-> $past(cnt_r[0]) >= 32'(FILTER_CYCLES - 1))
        else $error("channel changed before filter time");
    // the two cycles after reset still see raw history from reset time
    a_sync_two_stage: assert property
        (sync2_r == $past(raw, 2) || !$past(rst_n) || !$past(rst_n, 2))
        else $error("synchroniser depth wrong");
    a_overspeed_alarm: assert property
        (err_speed && !alarm_r && !cutoff && !restore_err
         |=> alarm_r && code_r == ERR_OVERSPEED)
        else $error("over-speed not raised");
    a_dbrake_alarm: assert property
        (alarm_r |=> dyn_brake_out == $past(cfg_r.alarm_stop_sequence))
        else $error("dynamic brake ignores alarm sequence");
    a_brake_slow: assert property (st_r == ST_HOLD && slow |=> st_r == ST_STOP)
        else $error("brake not engaged at low speed");
    a_clamp_limit: assert property
        (run && !cutoff && over |=> thrust_limit_active_out && (thrust_out == $past(lim_s)
         || thrust_out == 16'(-$past(lim_s))))
        else $error("thrust not clamped");
endmodule

/* safety_ctrl_model.sv */
// Purpose: safety controller model driving both safety channels
// Assumes: channel high means on; on/off requests come from the bench
// Notes:   a diag request drops both channels for DIAG_CYC cycles
`timescale 1ns/1ns
module safety_ctrl_model #(
    parameter int DIAG_CYC = 3
)(
    input  wire logic clk_in,
    input  wire logic upper_on_in,
    input  wire logic lower_on_in,
    input  wire logic diag_in,
    output logic      upper_out,
    output logic      lower_out
);
    int diag_cnt = 0;
    // self-diagnosis low pulse, kept shorter than the device filter
    always @(posedge clk_in)
        diag_cnt <= diag_in ? DIAG_CYC : (diag_cnt > 0 ? diag_cnt - 1 : 0);
    // off requests are held by the caller well beyond the filter time
    assign upper_out = upper_on_in && (diag_cnt == 0);
    assign lower_out = lower_on_in && (diag_cnt == 0);
endmodule

/* testbench.sv */
// Purpose: self-checking bench for the safe thrust cutoff monitor
// Assumes: short filter and millisecond counts set by parameters
// Notes:   channels come from the safety controller model
`timescale 1ns/1ns
module testbench;
    import sto_pkg::*;
    localparam int FC       = 8;
    localparam int SETTLE   = FC + 6;
    localparam int OFF_HOLD = 5 * FC - SETTLE + 1; // off time past 5 ms
    logic               clk;
    logic               rst_n, servo_on, pos_mode, wr, rd, up_on, lo_on, diag, sf_u, sf_l;
    logic [15:0]        speed;
    logic signed [31:0] dcmd, dfb, pos;
    logic signed [15:0] tcmd, thr;
    logic [7:0]         addr, code;
    logic [31:0]        wdata, rdata, rv;
    logic               g_up, g_lo, mon, rdy, alm, dbr, brel, tla;
    int                 n_errors, n_checks, cycles;
    // device under test with shortened counts
    safe_thrust_off_monitor #(.FILTER_CYCLES(FC), .MS_CYCLES(4)) u_dut (
        .ref_clk_in(clk), .rst_n_in(rst_n), .safety_in_upper_in(sf_u),
        .safety_in_lower_in(sf_l), .servo_on_in(servo_on), .position_mode_in(pos_mode),
        .motor_speed_in(speed), .dev_cmd_in(dcmd), .dev_fb_in(dfb), .motor_pos_in(pos),
        .thrust_cmd_in(tcmd), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .gate_upper_out(g_up), .gate_lower_out(g_lo),
        .safety_monitor_out(mon), .servo_ready_out(rdy), .alarm_out(alm),
        .err_code_out(code), .dyn_brake_out(dbr), .brake_release_out(brel),
        .thrust_out(thr), .thrust_limit_active_out(tla));
    // far-side safety equipment
    safety_ctrl_model u_ctrl (.clk_in(clk), .upper_on_in(up_on), .lower_on_in(lo_on),
        .diag_in(diag), .upper_out(sf_u), .lower_out(sf_l));
    // clock source
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang watchdog
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            n_errors = n_errors + 1;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // plain-port bus master cycles
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic clr();
        wr_reg(A_CTRL, 32'h1);
        cyc(2);
    endtask
    // channel request, held past the filter before returning
    task automatic set_ch(input logic u, input logic l);
        // lifting an off request waits until it stood longer than 5 ms
        if ((u && !up_on) || (l && !lo_on))
            cyc(OFF_HOLD);
        @(posedge clk);
        up_on <= u;
        lo_on <= l;
        cyc(SETTLE);
    endtask
    // settings reset values, unmapped read, readback
    task automatic t_regs();
        logic [7:0]  ra [10] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
                                 8'h28, 8'h2c};
        logic [31:0] rr [10] = '{32'hffff, 32'hffffffff, 0, 32'h7fffffff, 0, 32'h7fff,
                                 32'h64, 0, 1, 1};
        for (int i = 0; i < 10; i++)
        begin
            rd_reg(ra[i], rv);
            chk(rv, rr[i]);
        end
        rd_reg(8'h30, rv);
        chk(rv, 0);
        wr_reg(A_DEVLIM, 32'h1234);
        rd_reg(A_DEVLIM, rv);
        chk(rv, 32'h1234);
    endtask
    // power-up alarm, restore, clear, run
    task automatic t_start();
        chk(32'(alm), 1);
        chk(32'(mon), 1);
        set_ch(1'b1, 1'b1);
        chk(32'(mon), 0);
        clr();
        chk(32'(alm), 0);
        chk(32'(rdy), 1);
        @(posedge clk);
        servo_on <= 1'b1;
        cyc(3);
        chk(32'({g_up, g_lo, brel}), 32'h7);
    endtask
    // every thrust limit selection, then an unclamped command
    task automatic t_thrust();
        @(posedge clk);
        tcmd <= 16'sh0200;
        wr_reg(A_TLIM1, 32'h100);
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(A_TLSEL, 32'(s));
            cyc(3);
            chk(32'(thr), s < 2 ? 32'h100 : 32'h200);
            chk(32'(tla), s < 2 ? 1 : 0);
        end
        wr_reg(A_TLSEL, 32'h0);
        @(posedge clk);
        tcmd <= 16'sh0050;
        cyc(3);
        chk(32'(thr), 32'h50);
        chk(32'(tla), 0);
    endtask
    // short self-diagnosis pulse is ignored
    task automatic t_diag();
        @(posedge clk);
        diag <= 1'b1;
        @(posedge clk);
        diag <= 1'b0;
        cyc(SETTLE);
        chk(32'({alm, g_up, g_lo}), 32'h3);
    endtask
    // cutoff while running, monitor table, early clear, restore
    task automatic t_safety();
        wr_reg(A_ALSEQ, 32'h0);
        wr_reg(A_BHOLD, 32'd10);
        @(posedge clk);
        speed <= 16'h0050;
        set_ch(1'b0, 1'b1);
        chk(32'({g_up, alm, rdy, mon, dbr}), 32'h08);
        chk(32'(code), 32'(ERR_SAFETY));
        chk(32'(thr), 0);
        chk(32'(brel), 1);
        rd_reg(A_STATUS, rv);
        chk(rv & 32'hff1f, 32'h1f13);
        cyc(50);
        chk(32'(brel), 0);
        clr();
        chk(32'(alm), 1);
        set_ch(1'b0, 1'b0);
        chk(32'({mon, g_lo}), 32'h2);
        set_ch(1'b1, 1'b0);
        chk(32'(mon), 0);
        set_ch(1'b1, 1'b1);
        chk(32'(alm), 1);
        @(posedge clk);
        servo_on <= 1'b0;
        speed <= 16'h0000;
        clr();
        chk(32'({alm, rdy, dbr}), 32'h3);
        // release speed above motor speed: brake engages at once, not after hold
        wr_reg(A_BRSPD, 32'h10);
        @(posedge clk);
        servo_on <= 1'b1;
        cyc(3);
        chk(32'(brel), 1);
        @(posedge clk);
        servo_on <= 1'b0;
        cyc(3);
        chk(32'(brel), 0);
    endtask
    // drive one protection input: speed, cmd dev, fb dev, position
    task automatic poke(input int k, input logic [31:0] v);
        @(posedge clk);
        case (k)
            0: speed <= v[15:0];
            1: dcmd <= v;
            2: dfb <= v;
            default: pos <= v;
        endcase
    endtask
    // limit reached is quiet, one above trips, then recover
    task automatic err_case(input int k, input logic [7:0] a, input logic [7:0] c);
        wr_reg(a, 32'h40);
        poke(k, 32'h40);
        cyc(3);
        chk(32'(alm), 0);
        poke(k, 32'h41);
        cyc(3);
        chk(32'({alm, code}), {23'h0, 1'b1, c});
        poke(k, 0);
        clr();
        chk(32'(alm), 0);
    endtask
    // protection errors with source select both ways
    task automatic t_protect();
        @(posedge clk);
        pos_mode <= 1'b1;
        dfb <= 32'sh1000;
        err_case(0, A_OVSPD, ERR_OVERSPEED);
        err_case(1, A_DEVLIM, ERR_DEVIATION);
        // feedback side quiet before the select flips, then command far off
        poke(2, 32'h0);
        wr_reg(A_DEVSRC, 32'h1);
        poke(1, 32'h1000);
        err_case(2, A_DEVLIM, ERR_DEVIATION);
        err_case(3, A_RANGE, ERR_SOFTLIMIT);
    endtask
    // main sequence
    initial
    begin
        {n_errors, n_checks, cycles} = '0;
        {rst_n, servo_on, pos_mode, wr, rd, up_on, lo_on, diag} = '0;
        {speed, dcmd, dfb, pos, tcmd, addr, wdata} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        cyc(3);
        t_regs();
        t_start();
        t_thrust();
        t_diag();
        t_safety();
        t_protect();
        stop_test();
    end
endmodule
